// >>> design/txc_map.svh
// register offsets, field positions and reset values of the transmit control block
// How it works
// - control at 70h, reserved bits read zero
// - bit 15 write flushes status FIFO pointers
// - bit 14 write flushes data FIFO pointers
// - overrun-allow low suspends on full status
// - overrun-allow high keeps transmitter running
// - full interrupt independent of overrun-allow
// - enable bit lets queued frames go
// - enable clears itself after requested halt
// - stop finishes current frame, then halts
// - stop bit clears once transmitter stopped
// - stop bit ignores writes while high
// - hardware setup register at 74h
`ifndef TXC_MAP_SVH
`define TXC_MAP_SVH
`define TXC_ADDR_W         12
`define TXC_CTRL_OFS       12'h070
`define TXC_SETUP_OFS      12'h074
`define TXC_STAT_OFS       12'h078
`define TXC_MASK_OFS       12'h07c
`define TXC_STS_FLUSH_BIT  15
`define TXC_DAT_FLUSH_BIT  14
`define TXC_ALLOW_BIT      2
`define TXC_ON_BIT         1
`define TXC_STOP_BIT       0
`define TXC_EVT_W          3
`define TXC_EVT_HALT       0
`define TXC_EVT_FULL       1
`define TXC_EVT_SETUP      2
`define TXC_SETUP_RST      32'h0000_0000
`define TXC_EVT_RST        3'h0
`endif

// >>> design/txc_pkg.sv
// types shared by the transmit control block
package txc_pkg;
    typedef enum logic [1:0] {TX_OFF, TX_RUN, TX_SUSPEND, TX_DRAIN} txc_state_t;
endpackage

// >>> design/txc_apb_port.sv
// apb slave handshake: one wait state, registered answer
`timescale 1ns/100ps
module txc_apb_port (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    // decode result and read value from the register file
    input  wire logic        addrHit,
    input  wire logic [31:0] rdMux,
    // apb answer
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // write strobe on the completing edge
    output logic             wrStb
);
    wire accessPhase = psel & penable;
    wire firstAccess = accessPhase & ~pready;

    assign wrStb = accessPhase & pready & pwrite & addrHit;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= firstAccess;
            prdata  <= (firstAccess & ~pwrite & addrHit) ? rdMux : 32'h0000_0000;
            pslverr <= firstAccess & ~addrHit;
        end
    end
endmodule

// >>> design/txc_tx_seq.sv
// transmitter run, suspend and orderly-stop sequencer
`timescale 1ns/100ps
module txc_tx_seq (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // control bits
    input  wire logic txOn,
    input  wire logic stopReq,
    input  wire logic overrunAllow,
    // transmit path state
    input  wire logic statusFull,
    input  wire logic frameActive,
    // results
    output logic      txRun,
    output logic      haltNow
);
    txc_pkg::txc_state_t state_r;
    txc_pkg::txc_state_t state_nxt;

    wire blockFull = statusFull & ~overrunAllow;

    assign haltNow = stopReq & ((state_r == txc_pkg::TX_OFF) |
                                ((state_r == txc_pkg::TX_DRAIN) & ~frameActive));

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            txc_pkg::TX_OFF:
                if (txOn & ~stopReq)
                    state_nxt = txc_pkg::TX_RUN;
            txc_pkg::TX_RUN:
                if (stopReq)
                    state_nxt = txc_pkg::TX_DRAIN;
                else if (~txOn)
                    state_nxt = txc_pkg::TX_OFF;
                else if (blockFull)
                    state_nxt = txc_pkg::TX_SUSPEND;
            txc_pkg::TX_SUSPEND:
                if (stopReq)
                    state_nxt = txc_pkg::TX_DRAIN;
                else if (~txOn)
                    state_nxt = txc_pkg::TX_OFF;
                else if (~blockFull)
                    state_nxt = txc_pkg::TX_RUN;
            txc_pkg::TX_DRAIN:
                if (~frameActive)
                    state_nxt = txc_pkg::TX_OFF;
            default:
                state_nxt = txc_pkg::TX_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= txc_pkg::TX_OFF;
            txRun   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            txRun   <= (state_nxt == txc_pkg::TX_RUN);
        end
    end
endmodule

// >>> design/txc_top.sv
// transmit control register bank with apb access, interrupts and transmit sequencing
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "txc_map.svh"
module txc_top (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TXC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // transmit path
    input  wire logic                   statusFull,
    input  wire logic                   frameActive,
    input  wire logic                   rxStopped,
    output logic                        txRun,
    output logic                        statusFlush,
    output logic                        dataFlush,
    // hardware setup value
    output logic [31:0]                 setupOut,
    // interrupt
    output logic                        irq
);
    logic                  allow_r;
    logic                  txOn_r;
    logic                  stop_r;
    logic                  fullPrev_r;
    logic [`TXC_EVT_W-1:0] stat_r;
    logic [`TXC_EVT_W-1:0] mask_r;

    wire haltNow;
    wire wrStb;

    // address decode
    wire hitCtrl  = (paddr == `TXC_CTRL_OFS);
    wire hitSetup = (paddr == `TXC_SETUP_OFS);
    wire hitStat  = (paddr == `TXC_STAT_OFS);
    wire hitMask  = (paddr == `TXC_MASK_OFS);
    wire addrHit  = hitCtrl | hitSetup | hitStat | hitMask;

    wire wrCtrl  = wrStb & hitCtrl;
    wire wrSetup = wrStb & hitSetup;
    wire wrStat  = wrStb & hitStat;
    wire wrMask  = wrStb & hitMask;

    // control view: reserved fields read zero
    wire [31:0] ctrlView = {16'h0000, statusFlush, dataFlush, 11'h000,
                            allow_r, txOn_r, stop_r};

    wire [31:0] rdMux = hitCtrl  ? ctrlView :
                        hitSetup ? setupOut :
                        hitStat  ? {29'h0000_0000, stat_r} :
                        hitMask  ? {29'h0000_0000, mask_r} :
                                   32'h0000_0000;

    txc_apb_port u_apb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .addrHit (addrHit),
        .rdMux   (rdMux),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .wrStb   (wrStb)
    );

    txc_tx_seq u_seq (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .txOn         (txOn_r),
        .stopReq      (stop_r),
        .overrunAllow (allow_r),
        .statusFull   (statusFull),
        .frameActive  (frameActive),
        .txRun        (txRun),
        .haltNow      (haltNow)
    );

    // control bit next values
    wire stopHalt = stop_r & haltNow;
    wire txOn_nxt = stopHalt ? 1'b0 :
                    wrCtrl   ? pwdata[`TXC_ON_BIT] : txOn_r;
    wire stop_nxt = stop_r ? ~haltNow :
                    wrCtrl ? pwdata[`TXC_STOP_BIT] : 1'b0;
    wire allow_nxt = wrCtrl ? pwdata[`TXC_ALLOW_BIT] : allow_r;

    // events: full rises regardless of overrun-allow
    wire fullRise = statusFull & ~fullPrev_r;
    wire setupBad = wrSetup & (txOn_r | stop_r | ~rxStopped);
    wire [`TXC_EVT_W-1:0] events = {setupBad, fullRise, stopHalt};
    wire [`TXC_EVT_W-1:0] clrMask = wrStat ? pwdata[`TXC_EVT_W-1:0] : `TXC_EVT_RST;
    // set wins over write-one-to-clear
    wire [`TXC_EVT_W-1:0] stat_nxt = (stat_r & ~clrMask) | events;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            allow_r <= 1'b0;
            txOn_r  <= 1'b0;
            stop_r  <= 1'b0;
        end
        else
        begin
            allow_r <= allow_nxt;
            txOn_r  <= txOn_nxt;
            stop_r  <= stop_nxt;
        end
    end

    // one-cycle flush strobes, self clearing
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            statusFlush <= 1'b0;
            dataFlush   <= 1'b0;
        end
        else
        begin
            statusFlush <= wrCtrl & pwdata[`TXC_STS_FLUSH_BIT];
            dataFlush   <= wrCtrl & pwdata[`TXC_DAT_FLUSH_BIT];
        end
    end

    // hardware setup register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            setupOut <= `TXC_SETUP_RST;
        else if (wrSetup)
            setupOut <= pwdata;
    end

    // interrupt status, mask and output
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stat_r     <= `TXC_EVT_RST;
            mask_r     <= `TXC_EVT_RST;
            fullPrev_r <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            stat_r     <= stat_nxt;
            mask_r     <= wrMask ? pwdata[`TXC_EVT_W-1:0] : mask_r;
            fullPrev_r <= statusFull;
            irq        <= |(stat_nxt & (wrMask ? pwdata[`TXC_EVT_W-1:0] : mask_r));
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ctrl_reserved_a: assert property ((ctrlView[31:16] == 16'h0000) && (ctrlView[13:3] == 11'h000))
        else $error("reserved control bits not zero");

    status_flush_a: assert property (wrCtrl && pwdata[`TXC_STS_FLUSH_BIT] |=> statusFlush ##1 !statusFlush)
        else $error("status flush strobe wrong");

    data_flush_a: assert property (wrCtrl && pwdata[`TXC_DAT_FLUSH_BIT] |=> dataFlush ##1 !dataFlush)
        else $error("data flush strobe wrong");

    flush_selfclr_a: assert property (!(wrCtrl && pwdata[`TXC_STS_FLUSH_BIT]) |=> !statusFlush)
        else $error("status flush bit set without write");

    full_suspend_a: assert property (txRun && txOn_r && !stop_r && statusFull && !allow_r |=> !txRun)
        else $error("transmit not suspended on full status");

    overrun_run_a: assert property (txRun && txOn_r && !stop_r && allow_r |=> txRun)
        else $error("transmit stopped despite overrun allow");

    full_irq_a: assert property ($rose(statusFull) |=> stat_r[`TXC_EVT_FULL])
        else $error("full event not latched");

    halt_clear_a: assert property (stop_r && haltNow |=> !stop_r && !txOn_r && stat_r[`TXC_EVT_HALT])
        else $error("stop completion did not clear control");

    stop_hold_a: assert property (stop_r && !haltNow |=> stop_r)
        else $error("stop bit dropped before halt");

    drain_norun_a: assert property (stop_r |=> !txRun)
        else $error("transmit runs while stopping");

    irq_level_a: assert property (|(stat_r & mask_r) |-> irq)
        else $error("interrupt low with unmasked event");

    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not after one wait state");

    apb_pulse_a: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");

    unmapped_err_a: assert property (psel && penable && !pready && !addrHit |=> pready && pslverr)
        else $error("unmapped access without error answer");

    rd_idle_a: assert property (!pready |-> (prdata == 32'h0000_0000))
        else $error("read data not zero outside answer");

    setup_store_a: assert property (wrSetup |=> (setupOut == $past(pwdata)))
        else $error("setup register not written");

    enable_store_a: assert property (wrCtrl && !stopHalt |=> (txOn_r == $past(pwdata[`TXC_ON_BIT])))
        else $error("enable bit not written");

    stop_write_a: assert property (wrCtrl && !stop_r |=> (stop_r == $past(pwdata[`TXC_STOP_BIT])))
        else $error("stop bit not written");
endmodule

// >>> dv/txc_testbench.sv
// self-checking bench for the transmit control register bank
`timescale 1ns/100ps
`include "txc_map.svh"
module testbench;
    logic                   sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic                   statusFull, frameActive, rxStopped, txRun, statusFlush, dataFlush, irq;
    logic [`TXC_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, setupOut, rd, d;
    logic                   err;
    logic [15:0]            lfsrV;
    int                     badCount, checks, cyc, sfCnt, dfCnt, sf0, df0;
    int                     ctrlM, statM, maskM, setupM;

    txc_top dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .statusFull(statusFull), .frameActive(frameActive), .rxStopped(rxStopped), .txRun(txRun),
        .statusFlush(statusFlush), .dataFlush(dataFlush), .setupOut(setupOut), .irq(irq));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task complete_run;
        if (badCount == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, expErr});
    endtask

    task settle;
        repeat (3) @(posedge sys_clk);
    endtask

    // timeout and flush pulse counters
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (statusFlush === 1'b1)
            sfCnt <= sfCnt + 1;
        if (dataFlush === 1'b1)
            dfCnt <= dfCnt + 1;
        if (cyc == 4000)
        begin
            badCount++;
            complete_run;
        end
    end

    initial
    begin
        rst         = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = '0;
        statusFull  = 1'b0;
        frameActive = 1'b0;
        rxStopped   = 1'b1;
        badCount    = 0;
        checks      = 0;
        cyc         = 0;
        sfCnt       = 0;
        dfCnt       = 0;
        lfsrV       = 16'hc1d8;
        ctrlM       = 0;
        statM       = 0;
        maskM       = 7;
        setupM      = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        rdc(`TXC_SETUP_OFS, setupM, 1'b0);
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        rdc(12'h080, 32'h0, 1'b1);
        apb(1'b1, `TXC_MASK_OFS, 32'hffffffff);
        rdc(`TXC_MASK_OFS, maskM, 1'b0);
        for (int a = 0; a < 2; a++)
        begin
            lfsrV = lfsr(lfsrV);
            d = ({lfsrV, lfsrV} & 32'hffff3ff8) | 32'h2 | (a << 2);
            ctrlM = d & 32'h6;
            apb(1'b1, `TXC_CTRL_OFS, d);
            rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
            chk({31'h0, txRun}, 32'h1);
            statusFull <= 1'b1;
            settle;
            statM = 2;
            chk({31'h0, txRun}, a);
            chk({31'h0, irq}, 32'h1);
            rdc(`TXC_STAT_OFS, statM, 1'b0);
            statusFull <= 1'b0;
            apb(1'b1, `TXC_STAT_OFS, 32'h2);
            statM = 0;
            settle;
            chk({31'h0, irq}, 32'h0);
            chk({31'h0, txRun}, 32'h1);
            rdc(`TXC_STAT_OFS, statM, 1'b0);
        end
        for (int i = 0; i < 2; i++)
        begin
            sf0 = sfCnt;
            df0 = dfCnt;
            apb(1'b1, `TXC_CTRL_OFS, 32'h6 | (32'h4000 << i));
            settle;
            chk(sfCnt - sf0, i);
            chk(dfCnt - df0, 1 - i);
            rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        end
        lfsrV = lfsr(lfsrV);
        setupM = {lfsrV, lfsr(lfsrV)};
        apb(1'b1, `TXC_SETUP_OFS, setupM);
        rdc(`TXC_SETUP_OFS, setupM, 1'b0);
        chk(setupOut, setupM);
        statM = 4;
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        apb(1'b1, `TXC_STAT_OFS, 32'h4);
        statM = 0;
        frameActive <= 1'b1;
        ctrlM = 7;
        apb(1'b1, `TXC_CTRL_OFS, 32'h7);
        settle;
        chk({31'h0, txRun}, 32'h0);
        rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        apb(1'b1, `TXC_CTRL_OFS, 32'h6);
        rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        frameActive <= 1'b0;
        settle;
        ctrlM = 4;
        statM = 1;
        rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        chk({31'h0, txRun}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        apb(1'b1, `TXC_STAT_OFS, 32'h1);
        statM = 0;
        apb(1'b1, `TXC_SETUP_OFS, 32'h0);
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        rxStopped <= 1'b0;
        apb(1'b1, `TXC_SETUP_OFS, setupM);
        statM = 4;
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        chk(setupOut, setupM);
        rxStopped <= 1'b1;
        apb(1'b1, `TXC_STAT_OFS, 32'h4);
        statM = 0;
        apb(1'b1, `TXC_CTRL_OFS, 32'h1);
        ctrlM = 0;
        statM = 1;
        rdc(`TXC_CTRL_OFS, ctrlM, 1'b0);
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        apb(1'b1, `TXC_STAT_OFS, 32'h1);
        statM = 0;
        settle;
        chk({31'h0, irq}, 32'h0);
        rdc(`TXC_STAT_OFS, statM, 1'b0);
        complete_run;
    end
endmodule
